// *** design/spi_eeprom_device.sv ***
// EEPROM device end: serial front end, status bits, page buffer and array
`timescale 1ns/100ps
module spi_eeprom_device
	import spi_eeprom_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	spi_link_if.device link,
	output logic standby,
	output logic selected,
	output logic paused,
	output logic write_busy,
	output logic block_protect_hi,
	output logic block_protect_lo
);
	logic [7:0] mem [0:MEM_BYTES-1];
	logic [7:0] page_buf [0:PAGE_BYTES-1];
	logic [4:0] meta_reg;
	logic [4:0] sync_reg;
	logic sclk_prev_reg;
	logic sel_prev_reg;
	dev_state_t state_reg, state_next;
	logic [2:0] bit_cnt_reg, bit_cnt_next;
	logic [1:0] byte_cnt_reg, byte_cnt_next;
	logic [7:0] rx_reg, rx_next;
	logic [7:0] cmd_reg, cmd_next;
	logic [16:0] addr_reg, addr_next;
	logic [7:0] tx_reg, tx_next;
	logic [7:0] sr_new_reg, sr_new_next;
	logic exec_ok_reg, exec_ok_next;
	logic drive_reg, drive_next;
	logic q_reg, q_next;
	logic q_oe_n_reg, q_oe_n_next;
	logic paused_reg, paused_next;
	logic armed_reg, armed_next;
	logic wel_reg, wel_next;
	logic wip_reg, wip_next;
	logic [1:0] bp_reg, bp_next;
	logic srwd_reg, srwd_next;
	logic [255:0] valid_reg, valid_next;
	logic [7:0] commit_idx_reg, commit_idx_next;
	logic [8:0] page_reg, page_next;
	logic standby_reg, standby_next;
	logic selected_reg, selected_next;
	logic buf_we;
	logic mem_we;
	logic sel_s, sclk_s, mosi_s, hold_s, wp_s;
	logic rise, fall, sel_rise, sel_fall, active;
	logic [7:0] shift_in;
	logic [7:0] status;
	logic [16:0] a;

	assign sel_s = sync_reg[0];
	assign sclk_s = sync_reg[1];
	assign mosi_s = sync_reg[2];
	assign hold_s = sync_reg[3];
	assign wp_s = sync_reg[4];
	assign rise = sclk_s & ~sclk_prev_reg;
	assign fall = ~sclk_s & sclk_prev_reg;
	assign sel_rise = sel_s & ~sel_prev_reg;
	assign sel_fall = ~sel_s & sel_prev_reg;
	// Clock edges are gated off while paused
	assign active = ~sel_s & armed_reg & ~paused_reg;
	assign shift_in = {rx_reg[6:0], mosi_s};

	always_comb begin
		status = 8'h00;
		status[SR_WIP] = wip_reg;
		status[SR_WEL] = wel_reg;
		status[SR_BP_LO] = bp_reg[0];
		status[SR_BP_HI] = bp_reg[1];
		status[SR_SRWD] = srwd_reg;
	end

	always_comb begin
		state_next = state_reg;
		bit_cnt_next = bit_cnt_reg;
		byte_cnt_next = byte_cnt_reg;
		rx_next = rx_reg;
		cmd_next = cmd_reg;
		addr_next = addr_reg;
		tx_next = tx_reg;
		sr_new_next = sr_new_reg;
		exec_ok_next = exec_ok_reg;
		drive_next = drive_reg;
		q_next = q_reg;
		wel_next = wel_reg;
		wip_next = wip_reg;
		bp_next = bp_reg;
		srwd_next = srwd_reg;
		valid_next = valid_reg;
		commit_idx_next = commit_idx_reg;
		page_next = page_reg;
		buf_we = 1'b0;
		mem_we = 1'b0;
		a = addr_reg;
		// Level test also covers a pause request made while the clock is high
		if (paused_reg) begin
			paused_next = ~(hold_s & ~sclk_s);
		end else begin
			paused_next = ~hold_s & ~sclk_s & ~sel_s;
		end
		armed_next = armed_reg | sel_fall;
		if (sel_s) begin
			paused_next = 1'b0;
			state_next = DS_OPCODE;
			bit_cnt_next = 3'h0;
			byte_cnt_next = 2'h0;
			drive_next = 1'b0;
			exec_ok_next = 1'b0;
		end else if (active && rise) begin
			// Any rise after the boundary spoils execution
			exec_ok_next = 1'b0;
			rx_next = shift_in;
			bit_cnt_next = bit_cnt_reg + 3'h1;
			if (bit_cnt_reg == 3'h7) begin
				case (state_reg)
					DS_OPCODE: begin
						cmd_next = shift_in;
						if (!op_known(shift_in)) begin
							state_next = DS_IGNORE;
						end else if (wip_reg && shift_in != OP_RDSR) begin
							state_next = DS_IGNORE;
						end else if (shift_in == OP_WREN || shift_in == OP_WRDI) begin
							state_next = DS_WAIT;
							exec_ok_next = 1'b1;
						end else if (shift_in == OP_RDSR) begin
							state_next = DS_DATA;
							tx_next = status;
						end else if (shift_in == OP_WRSR) begin
							state_next = DS_DATA;
						end else begin
							state_next = DS_ADDR;
							byte_cnt_next = 2'h0;
						end
					end
					DS_ADDR: begin
						a = {addr_reg[8:0], shift_in};
						addr_next = a;
						byte_cnt_next = byte_cnt_reg + 2'h1;
						if (byte_cnt_reg == ADDR_LAST) begin
							state_next = DS_DATA;
							tx_next = mem[a];
						end
					end
					DS_DATA: begin
						case (cmd_reg)
							OP_WRITE: begin
								buf_we = 1'b1;
								valid_next[addr_reg[7:0]] = 1'b1;
								// Page write wraps inside the page
								addr_next = {addr_reg[16:8], addr_reg[7:0] + 8'h01};
								exec_ok_next = wel_reg & ~addr_protected(addr_reg, bp_reg);
							end
							OP_WRSR: begin
								sr_new_next = shift_in;
								state_next = DS_WAIT;
								exec_ok_next = wel_reg & ~(srwd_reg & ~wp_s);
							end
							OP_READ: begin
								a = addr_reg + 17'h00001;
								addr_next = a;
								tx_next = mem[a];
							end
							default: begin
								tx_next = status;
							end
						endcase
					end
					DS_WAIT: begin
						state_next = DS_IGNORE;
					end
					default: begin
						state_next = DS_IGNORE;
					end
				endcase
			end
		end else if (active && fall && state_reg == DS_DATA && (cmd_reg == OP_READ || cmd_reg == OP_RDSR)) begin
			q_next = tx_reg[7];
			tx_next = {tx_reg[6:0], 1'b0};
			drive_next = 1'b1;
		end
		// A pause in progress at deselect cancels the pending instruction
		if (sel_rise && !paused_reg && exec_ok_reg && armed_reg) begin
			case (cmd_reg)
				OP_WREN: wel_next = 1'b1;
				OP_WRDI: wel_next = 1'b0;
				OP_WRSR: begin
					wel_next = 1'b0;
					bp_next = {sr_new_reg[SR_BP_HI], sr_new_reg[SR_BP_LO]};
					srwd_next = sr_new_reg[SR_SRWD];
				end
				OP_WRITE: begin
					wel_next = 1'b0;
					wip_next = 1'b1;
					commit_idx_next = 8'h00;
					page_next = addr_reg[16:8];
				end
				default: begin
					wel_next = wel_reg;
				end
			endcase
		end else if (sel_rise && !wip_reg) begin
			valid_next = '0;
		end
		// Commit walks the whole page, one byte per clock
		if (wip_reg) begin
			mem_we = valid_reg[commit_idx_reg];
			commit_idx_next = commit_idx_reg + 8'h01;
			if (commit_idx_reg == PAGE_LAST) begin
				wip_next = 1'b0;
				valid_next = '0;
			end
		end
		q_oe_n_next = ~(drive_next & ~sel_s & armed_reg & ~paused_next);
		standby_next = sel_s & ~wip_next;
		selected_next = ~sel_s & armed_next;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			// Clock bit resets low like the idle clock, so no false edge follows reset
			meta_reg <= 5'h1D;
			sync_reg <= 5'h1D;
			sclk_prev_reg <= 1'b0;
			sel_prev_reg <= 1'b1;
			state_reg <= DS_OPCODE;
			bit_cnt_reg <= 3'h0;
			byte_cnt_reg <= 2'h0;
			rx_reg <= 8'h00;
			cmd_reg <= 8'h00;
			addr_reg <= 17'h00000;
			tx_reg <= 8'h00;
			sr_new_reg <= 8'h00;
			exec_ok_reg <= 1'b0;
			drive_reg <= 1'b0;
			q_reg <= 1'b0;
			q_oe_n_reg <= 1'b1;
			paused_reg <= 1'b0;
			armed_reg <= 1'b0;
			wel_reg <= 1'b0;
			wip_reg <= 1'b0;
			bp_reg <= 2'h0;
			srwd_reg <= 1'b0;
			valid_reg <= '0;
			commit_idx_reg <= 8'h00;
			page_reg <= 9'h000;
			standby_reg <= 1'b1;
			selected_reg <= 1'b0;
		end else begin
			meta_reg <= {link.wp_n, link.hold_n, link.mosi, link.sclk, link.sel_n};
			sync_reg <= meta_reg;
			sclk_prev_reg <= sclk_s;
			sel_prev_reg <= sel_s;
			state_reg <= state_next;
			bit_cnt_reg <= bit_cnt_next;
			byte_cnt_reg <= byte_cnt_next;
			rx_reg <= rx_next;
			cmd_reg <= cmd_next;
			addr_reg <= addr_next;
			tx_reg <= tx_next;
			sr_new_reg <= sr_new_next;
			exec_ok_reg <= exec_ok_next;
			drive_reg <= drive_next;
			q_reg <= q_next;
			q_oe_n_reg <= q_oe_n_next;
			paused_reg <= paused_next;
			armed_reg <= armed_next;
			wel_reg <= wel_next;
			wip_reg <= wip_next;
			bp_reg <= bp_next;
			srwd_reg <= srwd_next;
			valid_reg <= valid_next;
			commit_idx_reg <= commit_idx_next;
			page_reg <= page_next;
			standby_reg <= standby_next;
			selected_reg <= selected_next;
		end
	end

	// Arrays carry no reset; contents are undefined until written
	always_ff @(posedge clk) begin
		if (buf_we) begin
			page_buf[addr_reg[7:0]] <= shift_in;
		end
		if (mem_we) begin
			mem[{page_reg, commit_idx_reg}] <= page_buf[commit_idx_reg];
		end
	end

	assign link.q_out = q_reg;
	assign link.q_oe_n = q_oe_n_reg;
	assign standby = standby_reg;
	assign selected = selected_reg;
	assign paused = paused_reg;
	assign write_busy = wip_reg;
	assign block_protect_hi = bp_reg[1];
	assign block_protect_lo = bp_reg[0];
endmodule : spi_eeprom_device

// *** design/spi_eeprom_pkg.sv ***
// Shared constants and types for both ends of the serial EEPROM link
// Function
// - Device drives output after clock falling edges
// - Device samples input on clock rising edges
// - Deselected device floats its output
// - Deselected and not writing means standby
// - Instructions need a select falling edge first
// - Pause suspends transfer, resumes where left
// - Paused device floats output, ignores clock, input
// - Host pauses only while selected
// - Write protect locks block protect bits
// - Host holds write protect steady per write
// - Incoming bytes travel most significant bit first
// - First bit taken at first rise after select
// - Read data MSB first, from first fall
// - Works in both positive clock modes
// - Host idles clock at its polarity level
// - Host selects only one device at once
// - Memory holds 512 pages of 256 bytes
// - Pause begins and ends only with clock low
// - Deselect while paused abandons everything
// - Execute only if select rises on boundary
// - Unknown opcode ignored until next deselect
package spi_eeprom_pkg;
	localparam int PAGE_BYTES = 256;
	localparam int PAGES = 512;
	localparam int MEM_BYTES = PAGE_BYTES * PAGES;
	localparam int ADDR_W = 17;
	localparam logic [1:0] ADDR_LAST = 2'h2;
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam logic [7:0] OP_WRITE = 8'h02;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam int SR_WIP = 0;
	localparam int SR_WEL = 1;
	localparam int SR_BP_LO = 2;
	localparam int SR_BP_HI = 3;
	localparam int SR_SRWD = 7;
	localparam logic [16:0] PROT_QUARTER = 17'h18000;
	localparam logic [16:0] PROT_HALF = 17'h10000;
	localparam logic [7:0] PAGE_LAST = 8'hFF;
	localparam int CLK_PERIOD_NS = 4;
	localparam int SCLK_PERIOD_NS = 160;
	localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF_CYCLES - 1);

	typedef enum logic [4:0] {
		DS_OPCODE = 5'h01,
		DS_ADDR = 5'h02,
		DS_DATA = 5'h04,
		DS_WAIT = 5'h08,
		DS_IGNORE = 5'h10
	} dev_state_t;

	typedef enum logic [5:0] {
		HS_IDLE = 6'h01,
		HS_SETUP = 6'h02,
		HS_LOW = 6'h04,
		HS_HIGH = 6'h08,
		HS_GAP = 6'h10,
		HS_END = 6'h20
	} host_state_t;

	function automatic logic addr_protected(input logic [16:0] a, input logic [1:0] bp);
		case (bp)
			2'h0: addr_protected = 1'b0;
			2'h1: addr_protected = (a >= PROT_QUARTER);
			2'h2: addr_protected = (a >= PROT_HALF);
			default: addr_protected = 1'b1;
		endcase
	endfunction : addr_protected

	function automatic logic op_known(input logic [7:0] op);
		op_known = (op == OP_WREN) || (op == OP_WRDI) || (op == OP_RDSR) ||
			(op == OP_WRSR) || (op == OP_READ) || (op == OP_WRITE);
	endfunction : op_known
endpackage : spi_eeprom_pkg

// *** design/spi_link_if.sv ***
// Serial link between the bus master and the EEPROM device
`timescale 1ns/100ps
interface spi_link_if;
	logic sel_n;
	logic sclk;
	logic mosi;
	logic hold_n;
	logic wp_n;
	logic q_out;
	logic q_oe_n;
	wire q_line;

	// Released line shows the inverse of the last bit, so a late sample shows up as wrong data
	assign q_line = q_oe_n ? ~q_out : q_out;

	modport device(input sel_n, input sclk, input mosi, input hold_n, input wp_n, output q_out, output q_oe_n);
	modport host(output sel_n, output sclk, output mosi, output hold_n, output wp_n, input q_line);
endinterface : spi_link_if

// *** design/spi_eeprom_host.sv ***
// Bus master end: byte-wide command port driving the serial link
`timescale 1ns/100ps
module spi_eeprom_host
	import spi_eeprom_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	spi_link_if.host link,
	input wire logic cpol,
	input wire logic wp_level,
	input wire logic hold_req,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_data,
	input wire logic cmd_last,
	output logic cmd_ready,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic busy
);
	host_state_t state_reg, state_next;
	logic [7:0] cnt_reg, cnt_next;
	logic [2:0] bit_reg, bit_next;
	logic [7:0] tx_reg, tx_next;
	logic [7:0] rx_reg, rx_next;
	logic last_reg, last_next;
	logic cpol_reg, cpol_next;
	logic sel_n_reg, sel_n_next;
	logic sclk_reg, sclk_next;
	logic hold_n_reg, hold_n_next;
	logic wp_n_reg, wp_n_next;
	logic ready_reg, ready_next;
	logic [7:0] rx_data_reg, rx_data_next;
	logic rx_valid_reg, rx_valid_next;
	logic busy_reg, busy_next;
	logic miso_meta_reg, miso_sync_reg;
	logic half_done;
	logic take;

	assign half_done = (cnt_reg == HALF_LAST);
	assign take = cmd_valid & ready_reg;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg + 8'h01;
		bit_next = bit_reg;
		tx_next = tx_reg;
		rx_next = rx_reg;
		last_next = last_reg;
		cpol_next = cpol_reg;
		sel_n_next = sel_n_reg;
		sclk_next = sclk_reg;
		hold_n_next = hold_n_reg;
		wp_n_next = wp_n_reg;
		ready_next = ready_reg;
		rx_data_next = rx_data_reg;
		rx_valid_next = 1'b0;
		case (state_reg)
			HS_IDLE: begin
				// Clock follows the polarity while deselected; a change needs idle cycles before the next frame
				cpol_next = cpol;
				sclk_next = cpol;
				if (take) begin
					wp_n_next = wp_level;
					tx_next = cmd_data;
					last_next = cmd_last;
					sel_n_next = 1'b0;
					ready_next = 1'b0;
					cnt_next = 8'h00;
					state_next = HS_SETUP;
				end
			end
			HS_SETUP: begin
				if (half_done) begin
					sclk_next = 1'b0;
					bit_next = 3'h0;
					cnt_next = 8'h00;
					state_next = HS_LOW;
				end
			end
			HS_LOW: begin
				if (half_done) begin
					cnt_next = cnt_reg;
					if (hold_req) begin
						hold_n_next = 1'b0;
					end else if (!hold_n_reg) begin
						hold_n_next = 1'b1;
						cnt_next = 8'h00;
					end else begin
						sclk_next = 1'b1;
						rx_next = {rx_reg[6:0], miso_sync_reg};
						if (bit_reg == 3'h7) begin
							rx_data_next = {rx_reg[6:0], miso_sync_reg};
							rx_valid_next = 1'b1;
						end
						cnt_next = 8'h00;
						state_next = HS_HIGH;
					end
				end
			end
			HS_HIGH: begin
				if (half_done) begin
					cnt_next = 8'h00;
					if (bit_reg != 3'h7) begin
						bit_next = bit_reg + 3'h1;
						tx_next = {tx_reg[6:0], 1'b0};
						sclk_next = 1'b0;
						state_next = HS_LOW;
					end else if (last_reg) begin
						sel_n_next = 1'b1;
						state_next = HS_END;
					end else begin
						ready_next = 1'b1;
						state_next = HS_GAP;
					end
				end
			end
			HS_GAP: begin
				cnt_next = 8'h00;
				if (take) begin
					tx_next = cmd_data;
					last_next = cmd_last;
					ready_next = 1'b0;
					bit_next = 3'h0;
					sclk_next = 1'b0;
					state_next = HS_LOW;
				end
			end
			HS_END: begin
				if (half_done) begin
					sclk_next = cpol_reg;
					ready_next = 1'b1;
					state_next = HS_IDLE;
				end
			end
			default: begin
				state_next = HS_IDLE;
			end
		endcase
		busy_next = (state_next != HS_IDLE);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= HS_IDLE;
			cnt_reg <= 8'h00;
			bit_reg <= 3'h0;
			tx_reg <= 8'h00;
			rx_reg <= 8'h00;
			last_reg <= 1'b0;
			cpol_reg <= 1'b0;
			sel_n_reg <= 1'b1;
			sclk_reg <= 1'b0;
			hold_n_reg <= 1'b1;
			wp_n_reg <= 1'b1;
			ready_reg <= 1'b1;
			rx_data_reg <= 8'h00;
			rx_valid_reg <= 1'b0;
			busy_reg <= 1'b0;
			miso_meta_reg <= 1'b0;
			miso_sync_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			bit_reg <= bit_next;
			tx_reg <= tx_next;
			rx_reg <= rx_next;
			last_reg <= last_next;
			cpol_reg <= cpol_next;
			sel_n_reg <= sel_n_next;
			sclk_reg <= sclk_next;
			hold_n_reg <= hold_n_next;
			wp_n_reg <= wp_n_next;
			ready_reg <= ready_next;
			rx_data_reg <= rx_data_next;
			rx_valid_reg <= rx_valid_next;
			busy_reg <= busy_next;
			miso_meta_reg <= link.q_line;
			miso_sync_reg <= miso_meta_reg;
		end
	end

	assign link.sel_n = sel_n_reg;
	assign link.sclk = sclk_reg;
	assign link.mosi = tx_reg[7];
	assign link.hold_n = hold_n_reg;
	assign link.wp_n = wp_n_reg;
	assign cmd_ready = ready_reg;
	assign rx_data = rx_data_reg;
	assign rx_valid = rx_valid_reg;
	assign busy = busy_reg;
endmodule : spi_eeprom_host

// *** dv/spi_link_asserts.sv ***
// Concurrent checks on the serial link between host and device ends
`timescale 1ns/100ps
module spi_link_asserts (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic sel_n,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic hold_n,
	input wire logic wp_n,
	input wire logic q_out,
	input wire logic q_oe_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Five cycles covers the two-flop input sampling of the device
	AST_DESEL_FLOAT: assert property (sel_n [*5] |-> q_oe_n)
		else $error("data output driven while deselected");
	AST_HOLD_FLOAT: assert property ((!hold_n && !sclk && !sel_n) [*5] |-> q_oe_n)
		else $error("data output driven while paused");
	AST_Q_AFTER_FALL: assert property ($changed(q_out) && !sel_n |-> !sclk && !$past(sclk, 2))
		else $error("data output changed outside a low clock phase");
	AST_OE_ON_FALL: assert property ($fell(q_oe_n) |-> !sclk)
		else $error("output enabled while clock high");
	AST_FIRST_RISE: assert property ($fell(sel_n) |-> ##[39:41] $rose(sclk))
		else $error("first rising clock edge not at expected distance from select");
	AST_MOSI_SHIFT: assert property ($changed(mosi) && !sel_n && !$fell(sel_n) |-> !sclk)
		else $error("input data changed while clock high");
	AST_HOLD_SEL: assert property ($fell(hold_n) |-> !sel_n)
		else $error("pause started while deselected");
	AST_HOLD_LOW: assert property (!hold_n |-> !sclk)
		else $error("clock high during pause");
	AST_WP_STABLE: assert property (!sel_n && !$past(sel_n) |-> $stable(wp_n))
		else $error("write protect changed during a frame");
	// Output must let go of the shared line within the input sampling delay after deselect
	AST_ONE_DRIVER: assert property (!q_oe_n |-> !$past(sel_n, 3))
		else $error("data output driven after deselect");

	cover property ($fell(q_oe_n));
	cover property (!hold_n [*5]);
	cover property ($fell(sel_n) && sclk);
endmodule : spi_link_asserts

// *** dv/tb_serial_eeprom_spi_port.sv ***
// Self-checking bench: host end drives device end across the link
`timescale 1ns/100ps
module tb_serial_eeprom_spi_port
	import spi_eeprom_pkg::*;
;
	localparam int LIMIT = 4000;
	logic clk;
	logic reset_n;
	logic cpol;
	logic wp_level;
	logic hold_req;
	logic cmd_valid;
	logic [7:0] cmd_data;
	logic cmd_last;
	logic cmd_ready;
	logic [7:0] rx_data;
	logic rx_valid;
	logic busy;
	logic standby;
	logic selected;
	logic paused;
	logic write_busy;
	logic block_protect_hi;
	logic block_protect_lo;
	logic [7:0] tx_q[$];
	logic [7:0] rx_q[$];
	int err_count;
	int compares;

	spi_link_if link();

	spi_eeprom_host i_spi_eeprom_host (.clk(clk), .reset_n(reset_n), .link(link), .cpol(cpol),
		.wp_level(wp_level), .hold_req(hold_req), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
		.cmd_last(cmd_last), .cmd_ready(cmd_ready), .rx_data(rx_data), .rx_valid(rx_valid), .busy(busy));

	spi_eeprom_device i_spi_eeprom_device (.clk(clk), .reset_n(reset_n), .link(link), .standby(standby),
		.selected(selected), .paused(paused), .write_busy(write_busy),
		.block_protect_hi(block_protect_hi), .block_protect_lo(block_protect_lo));

	spi_link_asserts i_spi_link_asserts (.clk(clk), .reset_n(reset_n), .sel_n(link.sel_n),
		.sclk(link.sclk), .mosi(link.mosi), .hold_n(link.hold_n), .wp_n(link.wp_n),
		.q_out(link.q_out), .q_oe_n(link.q_oe_n));

	always #2 clk = ~clk;

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic fail_wait();
		err_count++;
		$display("MISMATCH at %0t: wait limit reached", $time);
		complete_run();
	endtask : fail_wait

	// One byte through the command port; request held until the edge that takes it
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r);
		int n;
		n = 0;
		cmd_data = d;
		cmd_last = last;
		cmd_valid = 1'b1;
		// Ready is looked at off the edge, so the following edge is the one that takes the byte
		while (cmd_ready !== 1'b1 && n < LIMIT) begin
			@(posedge clk);
			#1 n++;
		end
		@(posedge clk);
		#1 cmd_valid = 1'b0;
		while (rx_valid !== 1'b1 && n < LIMIT) begin
			@(posedge clk);
			#1 n++;
		end
		if (n >= LIMIT) fail_wait();
		r = rx_data;
	endtask : xfer

	task automatic frame();
		logic [7:0] r;
		int n;
		n = 0;
		rx_q = {};
		foreach (tx_q[i]) begin
			xfer(tx_q[i], i == tx_q.size() - 1, r);
			rx_q.push_back(r);
		end
		while (busy !== 1'b0 && n < LIMIT) begin
			@(posedge clk);
			#1 n++;
		end
		if (n >= LIMIT) fail_wait();
	endtask : frame

	task automatic wait_commit();
		int n;
		n = 0;
		while (write_busy !== 1'b0 && n < LIMIT) begin
			@(posedge clk);
			#1 n++;
		end
		if (n >= LIMIT) fail_wait();
	endtask : wait_commit

	task automatic wr(input logic [23:0] a, input logic [7:0] d, input logic ok);
		tx_q = {OP_WREN};
		frame();
		tx_q = {OP_WRITE, a[23:16], a[15:8], a[7:0], d};
		frame();
		check(8'({write_busy, standby}), {6'h00, ok, !ok}, "commit state");
		wait_commit();
	endtask : wr

	task automatic rd(input logic [23:0] a);
		tx_q = {OP_READ, a[23:16], a[15:8], a[7:0], 8'h00};
		frame();
	endtask : rd

	task automatic rdsr();
		tx_q = {OP_RDSR, 8'h00};
		frame();
	endtask : rdsr

	initial begin
		int n;
		clk = 1'b0;
		reset_n = 1'b0;
		cpol = 1'b0;
		wp_level = 1'b1;
		hold_req = 1'b0;
		cmd_valid = 1'b0;
		cmd_data = 8'h00;
		cmd_last = 1'b0;
		err_count = 0;
		compares = 0;
		repeat (5) @(posedge clk);
		#1 reset_n = 1'b1;
		check(8'({standby, selected, link.q_oe_n}), 8'h05, "after reset");
		rdsr();
		check(rx_q[1], 8'h00, "status idle");
		tx_q = {OP_WREN};
		frame();
		rdsr();
		check(rx_q[1], 8'h02, "latch set");
		// Unknown opcode must swallow the disable that follows in the same frame
		tx_q = {8'hFF, OP_WRDI};
		frame();
		rdsr();
		check(rx_q[1], 8'h02, "unknown opcode");
		tx_q = {OP_WRDI};
		frame();
		rdsr();
		check(rx_q[1], 8'h00, "latch cleared");
		wr(24'h018000, 8'h5A, 1'b1);
		wait_commit();
		check(8'(standby), 8'h01, "standby after commit");
		rd(24'h018000);
		check(rx_q[4], 8'h5A, "read back");
		tx_q = {OP_WREN};
		frame();
		tx_q = {OP_WRSR, 8'h04};
		frame();
		wait_commit();
		check(8'({block_protect_hi, block_protect_lo}), 8'h01, "protect bits");
		rdsr();
		check(rx_q[1], 8'h04, "status after write");
		wr(24'h018000, 8'hA5, 1'b0);
		rd(24'h018000);
		check(rx_q[4], 8'h5A, "protected byte");
		tx_q = {OP_WREN};
		frame();
		tx_q = {OP_WRITE, 8'h00, 8'h00, 8'hFF, 8'h11, 8'h22};
		frame();
		wait_commit();
		rd(24'h0000FF);
		check(rx_q[4], 8'h11, "page end");
		// Second mode: clock idles high between frames
		cpol = 1'b1;
		// Two idle edges let the clock settle at its new level before select falls
		repeat (2) @(posedge clk);
		#1 rd(24'h000000);
		check(rx_q[4], 8'h22, "page wrap in mode three");
		check(8'(link.sclk), 8'h01, "idle clock high");
		fork
			rd(24'h0000FF);
			begin
				repeat (1500) @(posedge clk);
				#1 hold_req = 1'b1;
				n = 0;
				while (paused !== 1'b1 && n < 200) begin
					@(posedge clk);
					#1 n++;
				end
				if (n >= 200) fail_wait();
				repeat (5) @(posedge clk);
				#1 check(8'({paused, selected, link.q_oe_n}), 8'h07, "paused");
				hold_req = 1'b0;
			end
		join
		check(rx_q[4], 8'h11, "read across pause");
		cpol = 1'b0;
		repeat (2) @(posedge clk);
		#1 rdsr();
		check(8'(link.sclk), 8'h00, "idle clock low");
		complete_run();
	end
endmodule : tb_serial_eeprom_spi_port
